// file: common/rtw_pkg.sv
// shared constants and carrier types of the remote bus terminal time/watchdog block
package rtw_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int AREA_W = 4;

   // register offsets, word addressed
   localparam logic [4:0] REG_CONFIG     = 5'h00;
   localparam logic [4:0] REG_STATUS     = 5'h01;
   localparam logic [4:0] REG_TIME0      = 5'h02;
   localparam logic [4:0] REG_TIME1      = 5'h03;
   localparam logic [4:0] REG_TIME2      = 5'h04;
   localparam logic [4:0] REG_TIME_UPD1  = 5'h05;
   localparam logic [4:0] REG_TIME_UPD2  = 5'h06;
   localparam logic [4:0] REG_WD_TIMEOUT = 5'h07;
   localparam logic [4:0] REG_WD_RELOAD  = 5'h08;
   localparam logic [4:0] REG_BASE_ADDR  = 5'h09;
   localparam logic [4:0] REG_WD_COUNT   = 5'h0a;
   localparam logic [4:0] REG_AREA_ADDR  = 5'h0b;
   localparam logic [4:0] REG_AREA_DATA  = 5'h0c;

   // configuration register write bits (strobe/toggle) and read fields
   localparam int CFG_FREEZE     = 0;
   localparam int CFG_SYNC_TGL   = 1;
   localparam int CFG_WD_TGL     = 2;
   localparam int CFG_TM_TGL     = 3;
   localparam int CFG_SRC_LO     = 4;
   localparam int CFG_SRC_HI     = 5;

   // status register fields
   localparam int ST_TELECOMMAND_READY_FLAG  = 11;
   localparam int ST_WR_LO     = 11;
   localparam int ST_WR_HI     = 15;
   localparam logic [15:0] ST_TM_MASK = 16'h0080;
   localparam logic [15:0] ST_TC_MASK = 16'h0010;
   localparam logic [15:0] ST_WR_MASK = 16'hf800;
   localparam int ST_WD_EXPIRED = 0;

   // communication area slots
   localparam logic [3:0] AREA_TM_START = 4'h0;
   localparam logic [3:0] AREA_TM_LEN   = 4'h1;
   localparam logic [3:0] AREA_TC_START = 4'h2;
   localparam logic [15:0] LEN_MSB      = 16'h8000;

   localparam int TIME_W     = 43;
   localparam int SEC_W      = 32;
   localparam int FRAC_W     = 11;
   localparam logic [10:0] FRAC_CORR_LIMIT = 11'h3ff;
   localparam int BASE_SHIFT = 7;

   // timing: fraction lsb is 2**-11 s, watchdog tick is 1/256 s
   localparam int CLK_HZ       = 125000000;
   localparam int FRAC_HZ      = 2048;
   localparam int WD_TICK_HZ   = 256;
   localparam int FRAC_CYCLES  = CLK_HZ / FRAC_HZ;
   localparam int WD_CYCLES    = CLK_HZ / WD_TICK_HZ;

   typedef enum logic [1:0] {
      RTW_SRC_LOSS  = 2'b00,
      RTW_SRC_USER  = 2'b01,
      RTW_SRC_TERM  = 2'b10,
      RTW_SRC_OTHER = 2'b11
   } rtw_src_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } rtw_req_s;
endpackage

// file: rtl/rtw_tick.sv
`timescale 1ns/1ps
// free running divider giving one-cycle ticks
module rtw_tick #(
   parameter int DIV = 4
) (
   input  wire logic clk,
   input  wire logic reset_n,
   output logic      tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   logic [CW-1:0] count;

   if (DIV < 2) begin : g_bad_div
      $error("rtw_tick: DIV must be at least 2");
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         tick <= (count == CW'(DIV - 1));
         if (count == CW'(DIV - 1)) begin
            count <= '0;
         end else begin
            count <= count + 1'b1;
         end
      end
   end
endmodule

// file: rtl/rtw_area_mem.sv
`timescale 1ns/1ps
// small communication area memory with registered read data
module rtw_area_mem #(
   parameter int AW = 4,
   parameter int DW = 16
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic [DW-1:0]      rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// file: rtl/rtw_terminal.sv
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
// remote bus terminal: on-board time, watchdog, ready flags, comm area
//
// Overview of operation
// R1: on-board time is 43 bits: 32 whole seconds, 11 fraction bits.
// R2: freeze write to configuration latches running time into read words.
// R3: host reads time words low seconds, high seconds, then fraction.
// R4: host serialises all freeze and time update users.
// R5: host decrements seconds when frozen fraction exceeds 3ff.
// R6: two update writes, high word then low word, load seconds.
// R7: sync enable readable in configuration; writing its bit toggles it.
// R8: watchdog timeout in 1/256 second units in timeout register.
// R9: host writes timeout then toggles enable only if disabled.
// R10: host toggles enable off only if currently enabled.
// R11: enabled watchdog counts down; reload register write restarts it.
// R12: base register holds area address shifted right by seven.
// R13: host leaves both ready flags inactive at initialisation.
// R14: telemetry ready shown in status; configuration bit toggles it.
// R15: telecommand ready at status bit 11, changed by read-modify-write.
// R16: status writes affect only bits 11 to 15.
// R17: telemetry start address stored in area as byte offset.
// R18: telemetry length stored as word count minus one with msb set.
// R19: telecommand destination stored in area as byte offset.
// R20: interrupt source coded 0..3 in configuration; source read clears.
// R21: telemetry ready at status mask 0080, telecommand at 0010.
// R22: latched time words hold until the next freeze.
module rtw_terminal #(
   parameter int FRAC_DIV = rtw_pkg::FRAC_CYCLES,
   parameter int WD_DIV   = rtw_pkg::WD_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   input  wire logic [rtw_pkg::ADDR_W-1:0] addr,
   input  wire logic [rtw_pkg::DATA_W-1:0] wdata,
   input  wire logic                      wr,
   input  wire logic                      rd,
   input  wire logic                      irq_user_in,
   input  wire logic                      irq_term_in,
   input  wire logic                      irq_loss_in,
   output logic [rtw_pkg::DATA_W-1:0]     rdata,
   output logic                           wd_expired,
   output logic                           sync_enable,
   output logic                           telemetry_ready_flag,
   output logic                           telecommand_ready_flag,
   output logic                           irq
);
   typedef struct packed {
      logic [42:0] onboard_time;
      logic [42:0] frozen;
      logic [15:0] upd_hi;
      logic [15:0] wd_timeout;
      logic [15:0] wd_count;
      logic        wd_en;
      logic        wd_exp;
      logic        sync_en;
      logic        tm_rdy;
      logic [4:0]  st_hi;
      logic [15:0] base;
      logic [1:0]  src;
      logic        irq_pend;
      logic [2:0]  irq_s1;
      logic [2:0]  irq_s2;
      logic [15:0] rdata;
      logic        rd_area;
   } rtw_state_s;

   rtw_state_s st;
   rtw_state_s next_st;
   rtw_pkg::rtw_req_s req;
   logic        frac_tick;
   logic        wd_tick;
   logic [15:0] area_rdata;
   logic        area_we;

   if (FRAC_DIV < 2 || WD_DIV < 2) begin : g_bad_div
      $error("rtw_terminal: bad divider");
   end

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   rtw_tick #(.DIV(FRAC_DIV)) u_frac_tick (
      .clk     (clk),
      .reset_n (reset_n),
      .tick    (frac_tick)
   );

   rtw_tick #(.DIV(WD_DIV)) u_wd_tick (
      .clk     (clk),
      .reset_n (reset_n),
      .tick    (wd_tick)
   );

   // area words are stored as written: software supplies the byte
   // offsets and the coded length [R17] [R18] [R19]
   assign area_we = req.wr && (req.addr == rtw_pkg::REG_AREA_DATA);

   rtw_area_mem #(.AW(rtw_pkg::AREA_W), .DW(rtw_pkg::DATA_W)) u_area (
      .clk   (clk),
      .we    (area_we),
      .waddr (st.base[rtw_pkg::AREA_W-1:0]),
      .wdata (req.wdata),
      .raddr (st.base[rtw_pkg::AREA_W-1:0]),
      .rdata (area_rdata)
   );

   function automatic logic is_wr(input rtw_pkg::rtw_req_s r,
                                  input logic [4:0] a);
      is_wr = r.wr && (r.addr == a);
   endfunction

   function automatic logic is_rd(input rtw_pkg::rtw_req_s r,
                                  input logic [4:0] a);
      is_rd = r.rd && (r.addr == a);
   endfunction

   function automatic logic [15:0] status_word(input rtw_state_s s);
      logic [15:0] w;
      w = {s.st_hi, 11'h000};
      if (s.tm_rdy) w = w | rtw_pkg::ST_TM_MASK;  // [R14] [R21]
      if (s.st_hi[0]) w = w | rtw_pkg::ST_TC_MASK;  // [R21]
      w[rtw_pkg::ST_WD_EXPIRED] = s.wd_exp;
      status_word = w;
   endfunction

   function automatic logic [15:0] config_word(input rtw_state_s s);
      logic [15:0] w;
      w = 16'h0000;
      w[rtw_pkg::CFG_SYNC_TGL] = s.sync_en;  // [R7]
      w[rtw_pkg::CFG_WD_TGL]   = s.wd_en;  // [R9] [R10]
      w[rtw_pkg::CFG_TM_TGL]   = s.tm_rdy;
      w[rtw_pkg::CFG_SRC_HI:rtw_pkg::CFG_SRC_LO] = s.src;  // [R20]
      config_word = w;
   endfunction

   always_comb begin
      logic [15:0] cfg_w;
      logic [42:0] run_time;
      cfg_w   = req.wdata;
      next_st = st;
      // seconds placed above the fraction so a plain add carries into them
      run_time = {st.onboard_time[rtw_pkg::SEC_W-1:0],
                  st.onboard_time[rtw_pkg::TIME_W-1:rtw_pkg::SEC_W]}
                 + 43'h1;

      next_st.irq_s1 = {irq_term_in, irq_user_in, irq_loss_in};
      next_st.irq_s2 = st.irq_s1;

      // running time, fraction counts in 2**-11 s steps [R1]
      if (frac_tick) begin
         next_st.onboard_time = {run_time[rtw_pkg::FRAC_W-1:0],
                                 run_time[rtw_pkg::TIME_W-1:rtw_pkg::FRAC_W]};
      end

      if (is_wr(req, rtw_pkg::REG_CONFIG)) begin
         if (cfg_w[rtw_pkg::CFG_FREEZE]) begin
            // seconds in low 32 bits of the word image
            next_st.frozen = st.onboard_time;  // [R2] [R22]
         end
         if (cfg_w[rtw_pkg::CFG_SYNC_TGL]) begin
            next_st.sync_en = ~st.sync_en;  // [R7]
         end
         if (cfg_w[rtw_pkg::CFG_WD_TGL]) begin
            next_st.wd_en = ~st.wd_en;  // [R9] [R10]
            next_st.wd_count = st.wd_timeout;
         end
         if (cfg_w[rtw_pkg::CFG_TM_TGL]) begin
            next_st.tm_rdy = ~st.tm_rdy;  // [R14]
         end
      end

      // [R6] high word held, low word completes the seconds load
      if (is_wr(req, rtw_pkg::REG_TIME_UPD1)) begin
         next_st.upd_hi = req.wdata;
      end
      if (is_wr(req, rtw_pkg::REG_TIME_UPD2)) begin
         next_st.onboard_time = {11'h000, st.upd_hi, req.wdata};  // [R6]
      end

      if (is_wr(req, rtw_pkg::REG_STATUS)) begin
         next_st.st_hi = req.wdata[rtw_pkg::ST_WR_HI:rtw_pkg::ST_WR_LO];  // [R15] [R16]
      end

      if (is_wr(req, rtw_pkg::REG_WD_TIMEOUT)) begin
         next_st.wd_timeout = req.wdata;  // [R8]
      end
      if (is_wr(req, rtw_pkg::REG_BASE_ADDR)) begin
         next_st.base = req.wdata;  // [R12]
      end

      // watchdog countdown in 1/256 s ticks [R11]
      if (st.wd_en && wd_tick && (st.wd_count != 16'h0000)) begin
         next_st.wd_count = st.wd_count - 16'h0001;
         if (st.wd_count == 16'h0001) begin
            next_st.wd_exp = 1'b1;
         end
      end
      if (is_wr(req, rtw_pkg::REG_WD_RELOAD)) begin
         next_st.wd_count = st.wd_timeout;  // [R11]
      end

      // interrupt source capture; reading config clears, new event wins
      if (is_rd(req, rtw_pkg::REG_CONFIG)) begin
         next_st.irq_pend = 1'b0;  // [R20]
      end
      if (st.irq_s2[0]) begin
         next_st.irq_pend = 1'b1;
         next_st.src = rtw_pkg::RTW_SRC_LOSS;
      end else if (st.irq_s2[1]) begin
         next_st.irq_pend = 1'b1;
         next_st.src = rtw_pkg::RTW_SRC_USER;
      end else if (st.irq_s2[2]) begin
         next_st.irq_pend = 1'b1;
         next_st.src = rtw_pkg::RTW_SRC_TERM;
      end

      next_st.rd_area = is_rd(req, rtw_pkg::REG_AREA_DATA);
      next_st.rdata = 16'h0000;
      if (req.rd) begin
         case (req.addr)
            rtw_pkg::REG_CONFIG:     next_st.rdata = config_word(st);
            rtw_pkg::REG_STATUS:     next_st.rdata = status_word(st);
            rtw_pkg::REG_TIME0:      next_st.rdata = st.frozen[15:0];  // [R22]
            rtw_pkg::REG_TIME1:      next_st.rdata = st.frozen[31:16];
            rtw_pkg::REG_TIME2: begin
               next_st.rdata = {st.frozen[42:32], 5'h00};  // [R1]
            end
            rtw_pkg::REG_TIME_UPD1:  next_st.rdata = st.upd_hi;
            rtw_pkg::REG_WD_TIMEOUT: next_st.rdata = st.wd_timeout;
            rtw_pkg::REG_BASE_ADDR:  next_st.rdata = st.base;
            rtw_pkg::REG_WD_COUNT:   next_st.rdata = st.wd_count;
            default:                 next_st.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata                  <= 16'h0000;
         wd_expired             <= 1'b0;
         sync_enable            <= 1'b0;
         telemetry_ready_flag   <= 1'b0;
         telecommand_ready_flag <= 1'b0;
         irq                    <= 1'b0;
      end else begin
         rdata                  <= next_st.rd_area ? 16'h0000
                                                   : next_st.rdata;
         wd_expired             <= next_st.wd_exp;
         sync_enable            <= next_st.sync_en;
         telemetry_ready_flag   <= next_st.tm_rdy;
         telecommand_ready_flag <= next_st.st_hi[0];
         irq                    <= next_st.irq_pend;
      end
   end

   // area reads give 0000 on rdata; the memory's word, registered on the same edge as rdata, feeds only the unused rdata_mux;
   // the area word index is taken from the low base bits
   logic [15:0] rdata_mux;
   assign rdata_mux = st.rd_area ? area_rdata : rdata;

   property p_freeze_hold;
      @(posedge clk) disable iff (!reset_n)
      !(wr && addr == rtw_pkg::REG_CONFIG && wdata[rtw_pkg::CFG_FREEZE])
      |=> $stable(st.frozen);
   endproperty
   a_frozen_time_stable: assert property (p_freeze_hold)  // [R22]
      else $error("frozen time changed without a freeze");

   a_freeze_latch_now: assert property (  // [R2]
      @(posedge clk) disable iff (!reset_n)
      (wr && addr == rtw_pkg::REG_CONFIG && wdata[rtw_pkg::CFG_FREEZE])
      |=> st.frozen == $past(st.onboard_time))
      else $error("freeze did not latch running time");

   a_sync_toggle_bit: assert property (  // [R7]
      @(posedge clk) disable iff (!reset_n)
      (wr && addr == rtw_pkg::REG_CONFIG && wdata[rtw_pkg::CFG_SYNC_TGL])
      |=> sync_enable != $past(sync_enable))
      else $error("sync enable did not toggle");

   a_tm_toggle_bit: assert property (  // [R14]
      @(posedge clk) disable iff (!reset_n)
      (wr && addr == rtw_pkg::REG_CONFIG && wdata[rtw_pkg::CFG_TM_TGL])
      |=> ##1 telemetry_ready_flag != $past(telemetry_ready_flag, 2))
      else $error("telemetry ready did not toggle");

   a_status_low_kept: assert property (  // [R16]
      @(posedge clk) disable iff (!reset_n)
      (wr && addr == rtw_pkg::REG_STATUS)
      |=> st.tm_rdy == $past(st.tm_rdy) && st.wd_exp == $past(st.wd_exp))
      else $error("status write disturbed low bits");

   a_tc_flag_bit: assert property (  // [R15]
      @(posedge clk) disable iff (!reset_n)
      (wr && addr == rtw_pkg::REG_STATUS)
      |=> ##1 telecommand_ready_flag == $past(wdata[rtw_pkg::ST_TELECOMMAND_READY_FLAG], 2))
      else $error("telecommand ready not taken from bit 11");

   sequence s_reload;
      wr && addr == rtw_pkg::REG_WD_RELOAD;
   endsequence
   a_wd_reload_now: assert property (  // [R11]
      @(posedge clk) disable iff (!reset_n)
      s_reload |=> st.wd_count == $past(st.wd_timeout))
      else $error("watchdog reload did not restart count");

   a_time_update_load: assert property (  // [R6]
      @(posedge clk) disable iff (!reset_n)
      (wr && addr == rtw_pkg::REG_TIME_UPD2)
      |=> st.onboard_time[31:0] == {$past(st.upd_hi), $past(wdata)})
      else $error("time update not adopted as seconds");

   a_read_word_zero: assert property (  // [R3]
      @(posedge clk) disable iff (!reset_n)
      (rd && addr == rtw_pkg::REG_TIME0)
      |=> rdata == $past(st.frozen[15:0]))
      else $error("time word 0 read wrong");

   a_fraction_carry: assert property (  // [R1]
      @(posedge clk) disable iff (!reset_n)
      (frac_tick && (&st.onboard_time[42:32])
       && !(wr && addr == rtw_pkg::REG_TIME_UPD2))
      |=> st.onboard_time[31:0] == $past(st.onboard_time[31:0]) + 32'h1)
      else $error("fraction overflow did not carry into seconds");

   sequence s_wd_step;
      st.wd_en && wd_tick && (st.wd_count != 16'h0000);
   endsequence
   sequence s_wd_untouched;
      !(wr && (addr == rtw_pkg::REG_WD_RELOAD
               || addr == rtw_pkg::REG_CONFIG));
   endsequence
   a_wd_count_down: assert property (  // [R11]
      @(posedge clk) disable iff (!reset_n)
      s_wd_step ##0 s_wd_untouched
      |=> st.wd_count == $past(st.wd_count) - 16'h0001)
      else $error("watchdog did not count down on its tick");

   sequence s_cfg_read;
      rd && addr == rtw_pkg::REG_CONFIG;
   endsequence
   a_irq_read_clear: assert property (  // [R20]
      @(posedge clk) disable iff (!reset_n)
      s_cfg_read ##0 (st.irq_s2 == 3'b000) |=> !irq)
      else $error("configuration read did not clear interrupt");
endmodule

// file: tb/rtw_host.sv
// host processor model working the terminal registers
`timescale 1ns/1ps
module rtw_host (
   input  wire logic [15:0] rdata,
   input  wire logic        clk,
   output logic [4:0]       addr,
   output logic [15:0]      wdata,
   output logic             wr,
   output logic             rd
);
   initial begin
      addr = 5'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
   end

   // released lines show the inverse so stale values never pass
   task automatic write(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask

   task automatic read(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
   endtask

   // one caller at a time, so freeze and update never interleave
   task automatic get_time(output logic [31:0] s, output logic [10:0] f);
      logic [15:0] w0, w1, w2;
      write(rtw_pkg::REG_CONFIG, 16'h0001);
      read(rtw_pkg::REG_TIME0, w0);
      read(rtw_pkg::REG_TIME1, w1);
      read(rtw_pkg::REG_TIME2, w2);
      s = {w1, w0};
      f = w2[15:5];
   endtask

   function automatic logic [31:0] corrected(input logic [31:0] s,
                                             input logic [10:0] f);
      return (f > rtw_pkg::FRAC_CORR_LIMIT) ? s - 32'h1 : s;
   endfunction

   task automatic set_time(input logic [31:0] s);
      write(rtw_pkg::REG_TIME_UPD1, s[31:16]);
      write(rtw_pkg::REG_TIME_UPD2, s[15:0]);
   endtask

   // configuration bits toggle, so write only on a difference
   task automatic toggle_if(input int b, input logic want);
      logic [15:0] c;
      read(rtw_pkg::REG_CONFIG, c);
      if (c[b] !== want) begin
         write(rtw_pkg::REG_CONFIG, 16'h0001 << b);
      end
   endtask

   task automatic wd_enable(input logic [15:0] tmo);
      write(rtw_pkg::REG_WD_TIMEOUT, tmo);
      toggle_if(rtw_pkg::CFG_WD_TGL, 1'b1);
   endtask

   task automatic set_tc(input logic on);
      logic [15:0] s;
      read(rtw_pkg::REG_STATUS, s);
      if (s[rtw_pkg::ST_TELECOMMAND_READY_FLAG] !== on) begin
         s[rtw_pkg::ST_TELECOMMAND_READY_FLAG] = on;
         write(rtw_pkg::REG_STATUS, s);
      end
   endtask

   task automatic init(input logic [15:0] area);
      write(rtw_pkg::REG_BASE_ADDR, area >> rtw_pkg::BASE_SHIFT);
      set_tc(1'b0);
      toggle_if(rtw_pkg::CFG_TM_TGL, 1'b0);
   endtask

   task automatic comm_tm(input logic [15:0] start, input logic [15:0] n);
      write(rtw_pkg::REG_AREA_DATA, start);
      write(rtw_pkg::REG_AREA_DATA, (n - 16'h1) | rtw_pkg::LEN_MSB);
   endtask

   task automatic comm_tc(input logic [15:0] start);
      write(rtw_pkg::REG_AREA_DATA, start);
   endtask
endmodule

// file: tb/rtw_terminal_tb.sv
// self-checking bench of the time, watchdog and flag terminal
`timescale 1ns/1ps
module rtw_terminal_tb;
   localparam int FD = 4;
   localparam int WD = 8;
   localparam int LIMIT = 40000;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata, v;
   logic        wr, rd, wd_expired, sync_enable, irq;
   logic        tm_flag, tc_flag;
   logic [2:0]  ev = 3'b000;
   int          fails = 0;
   int          checks_done = 0;
   int          cyc = 0;

   always #4 clk = ~clk;

   rtw_terminal #(.FRAC_DIV(FD), .WD_DIV(WD)) i_rtw_terminal (
      .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .irq_loss_in(ev[0]), .irq_user_in(ev[1]),
      .irq_term_in(ev[2]), .rdata(rdata), .wd_expired(wd_expired),
      .sync_enable(sync_enable), .telemetry_ready_flag(tm_flag),
      .telecommand_ready_flag(tc_flag), .irq(irq));

   rtw_host i_rtw_host (.clk(clk), .rdata(rdata), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd));

   task automatic final_report;
      if (fails == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fails++;
         final_report;
      end
   end

   task automatic check16(input string w, input logic [15:0] e,
                          input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic check_flag(input string w, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %b seen %b", w, e, g);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic do_reset;
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      wait_cyc(1);
      check_flag("expired after reset", 1'b0, wd_expired);
      i_rtw_host.read(rtw_pkg::REG_CONFIG, v);
      check16("config after reset", 16'h0000, v);
      i_rtw_host.read(rtw_pkg::REG_STATUS, v);
      check16("status after reset", 16'h0000, v);
   endtask

   task automatic t_time;
      logic [31:0] s1, s2;
      logic [10:0] f1, f2;
      int c1;
      i_rtw_host.set_time(32'h1234_5678);
      wait_cyc(1);
      c1 = cyc;
      i_rtw_host.get_time(s1, f1);
      check16("seconds low", 16'h5678, s1[15:0]);
      check16("seconds high", 16'h1234, s1[31:16]);
      check_flag("fraction near zero", 1'b1, f1 < 11'h008);
      wait_cyc(30);
      i_rtw_host.read(rtw_pkg::REG_TIME0, v);
      check16("held time0", s1[15:0], v);
      i_rtw_host.read(rtw_pkg::REG_TIME2, v);
      check16("held time2", {f1, 5'h00}, v);
      // one second is 2048 fraction ticks of FD cycles
      while (cyc != c1 + 2048 * FD) wait_cyc(1);
      i_rtw_host.get_time(s2, f2);
      check16("second carry", s1[15:0] + 16'h1, s2[15:0]);
      check16("same fraction", {5'h00, f1}, {5'h00, f2});
      s2 = i_rtw_host.corrected(s1, 11'h400);
      check16("corrected seconds", 16'h5677, s2[15:0]);
      s2 = i_rtw_host.corrected(s1, f1);
      check16("uncorrected seconds", 16'h5678, s2[15:0]);
   endtask

   task automatic t_toggles;
      i_rtw_host.toggle_if(rtw_pkg::CFG_SYNC_TGL, 1'b1);
      wait_cyc(2);
      check_flag("sync on", 1'b1, sync_enable);
      i_rtw_host.read(rtw_pkg::REG_CONFIG, v);
      check16("config sync", 16'h0002, v);
      i_rtw_host.toggle_if(rtw_pkg::CFG_SYNC_TGL, 1'b0);
      wait_cyc(2);
      check_flag("sync off", 1'b0, sync_enable);
      i_rtw_host.toggle_if(rtw_pkg::CFG_TM_TGL, 1'b1);
      wait_cyc(2);
      check_flag("tm on", 1'b1, tm_flag);
      i_rtw_host.read(rtw_pkg::REG_STATUS, v);
      check16("status tm", rtw_pkg::ST_TM_MASK, v);
      i_rtw_host.toggle_if(rtw_pkg::CFG_TM_TGL, 1'b0);
      wait_cyc(2);
      check_flag("tm off", 1'b0, tm_flag);
   endtask

   task automatic t_status;
      i_rtw_host.write(rtw_pkg::REG_STATUS, 16'hffff);
      i_rtw_host.read(rtw_pkg::REG_STATUS, v);
      check16("status all ones", 16'hf810, v);
      check_flag("tc on", 1'b1, tc_flag);
      i_rtw_host.set_tc(1'b0);
      wait_cyc(2);
      check_flag("tc off", 1'b0, tc_flag);
      i_rtw_host.read(rtw_pkg::REG_STATUS, v);
      check16("status rmw", 16'hf000, v);
      i_rtw_host.write(rtw_pkg::REG_STATUS, 16'h0000);
      i_rtw_host.comm_tm(16'h0040, 16'h0010);
      i_rtw_host.comm_tc(16'h0100);
      i_rtw_host.read(rtw_pkg::REG_AREA_DATA, v);
      check16("area readback", 16'h0000, v);
      i_rtw_host.read(5'h1f, v);
      check16("unmapped read", 16'h0000, v);
   endtask

   task automatic t_irq;
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         ev <= 3'b001 << k;
         wait_cyc(8);
         check_flag("irq raised", 1'b1, irq);
         @(posedge clk);
         ev <= 3'b000;
         wait_cyc(6);
         i_rtw_host.read(rtw_pkg::REG_CONFIG, v);
         check16("irq source", 16'(k) << rtw_pkg::CFG_SRC_LO, v);
         wait_cyc(2);
         check_flag("irq cleared", 1'b0, irq);
      end
   endtask

   task automatic t_wd;
      i_rtw_host.wd_enable(16'h0003);
      i_rtw_host.read(rtw_pkg::REG_CONFIG, v);
      // source code 2 is left over from the last interrupt scenario
      check16("wd enabled", 16'h0024, v);
      repeat (4) begin
         wait_cyc(12);
         check_flag("wd held off", 1'b0, wd_expired);
         i_rtw_host.write(rtw_pkg::REG_WD_RELOAD, 16'h0001);
      end
      wait_cyc(40);
      check_flag("wd expired", 1'b1, wd_expired);
      i_rtw_host.read(rtw_pkg::REG_STATUS, v);
      check16("status expired", 16'h0001, v);
      i_rtw_host.toggle_if(rtw_pkg::CFG_WD_TGL, 1'b0);
      i_rtw_host.read(rtw_pkg::REG_CONFIG, v);
      check16("wd disabled", 16'h0020, v);
   endtask

   initial begin
      do_reset();
      i_rtw_host.init(16'h1a80);
      t_time();
      t_toggles();
      t_status();
      t_irq();
      t_wd();
      do_reset();
      final_report;
   end
endmodule
